// ===== shared/aof_pkg.sv
package aof_pkg;
   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int AXIS_W   = 20;
   localparam int TRIM_W   = 16;
   localparam int THRESH_W = 16;
   localparam int FRAC_W   = 16;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] Z_OFFSET_TRIM_HIGH_ADDR    = 8'h22;
   localparam logic [7:0] Z_OFFSET_TRIM_LOW_ADDR     = 8'h23;
   localparam logic [7:0] MOTION_AXIS_ENABLES_ADDR   = 8'h24;
   localparam logic [7:0] MOTION_THRESHOLD_HIGH_ADDR = 8'h25;
   localparam logic [7:0] MOTION_THRESHOLD_LOW_ADDR  = 8'h26;
   localparam logic [7:0] MOTION_EVENT_COUNT_ADDR    = 8'h27;
   localparam logic [7:0] SIGNAL_PATH_CONFIG_ADDR    = 8'h28;
   localparam logic [7:0] IRQ_ROUTING_ADDR           = 8'h2A;

   // ---------------------------------------------------------------
   // reset values and field layout
   // ---------------------------------------------------------------
   localparam logic [7:0] BYTE_RESET          = 8'h00;
   localparam logic [7:0] EVENT_COUNT_RESET   = 8'h01;
   localparam logic [7:0] PATH_CONFIG_RESET   = 8'h00;
   localparam logic [7:0] AXIS_ENABLE_MASK    = 8'h07;
   localparam logic [7:0] PATH_CONFIG_MASK    = 8'h7F;
   localparam int         ENABLE_X_BIT        = 0;
   localparam int         ENABLE_Y_BIT        = 1;
   localparam int         ENABLE_Z_BIT        = 2;
   localparam int         HPF_SEL_LSB         = 4;
   localparam int         RATE_SEL_LSB        = 0;
   localparam int         IRQ_ONE_MOTION_BIT  = 3;
   localparam int         IRQ_TWO_MOTION_BIT  = 7;
   localparam logic [2:0] HPF_OFF_CODE        = 3'h0;
   localparam int         HPF_BASE_SHIFT      = 4;
   localparam int         TRIM_ALIGN_LSB      = 4;
   localparam int         THRESH_ALIGN_LSB    = 3;
endpackage : aof_pkg

// ===== logic/aof_hpf.sv
`timescale 1ns/10ps
module aof_hpf
   import aof_pkg::*;
#(
   parameter int W = AXIS_W
) (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rst,
   // sample in
   input  wire logic                valid_in,
   input  wire logic signed [W-1:0] sample_in,
   input  wire logic [2:0]          corner_sel_in,
   // sample out
   output logic                     valid_out,
   output logic signed [W-1:0]      sample_out
);
   if (W < 8) begin : g_bad_width
      $error("aof_hpf: width too small");
   end

   // ---------------------------------------------------------------
   // first-order stage: out = x - lowpass(x)
   // ---------------------------------------------------------------
   // shift grows by two per code, corner falls by four per code
   logic signed [W+FRAC_W:0] lp_reg;
   logic signed [W+FRAC_W:0] x_ext;
   logic signed [W+FRAC_W:0] diff;
   logic [5:0]               shift;
   logic signed [W:0]        hp_wide;

   assign x_ext   = {sample_in[W-1], sample_in, {FRAC_W{1'b0}}};
   assign diff    = x_ext - lp_reg;
   assign shift   = 6'(HPF_BASE_SHIFT) + {2'b00, corner_sel_in, 1'b0};
   assign hp_wide = {sample_in[W-1], sample_in}
                  - lp_reg[W+FRAC_W:FRAC_W];

   always_ff @(posedge clk) begin
      if (rst || corner_sel_in == HPF_OFF_CODE) begin
         lp_reg <= '0;
      end else if (valid_in) begin
         lp_reg <= lp_reg + (diff >>> shift);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         valid_out  <= 1'b0;
         sample_out <= '0;
      end else begin
         valid_out <= valid_in;
         if (valid_in) begin
            if (corner_sel_in == HPF_OFF_CODE) begin
               sample_out <= sample_in;
            end else if (hp_wide[W] != hp_wide[W-1]) begin
               sample_out <= hp_wide[W] ? {1'b1, {(W-1){1'b0}}}
                                        : {1'b0, {(W-1){1'b1}}};
            end else begin
               sample_out <= hp_wide[W-1:0];
            end
         end
      end
   end
endmodule : aof_hpf

// ===== logic/aof_top.sv
`timescale 1ns/10ps
// Summary of operation
// - z trim added after all filtering
// - trim two's complement, aligned to result bits 19:4
// - z trim bytes at 0x22/0x23, reset zero
// - axis joins activity only when enabled
// - count samples strictly above unsigned threshold
// - threshold aligned to result bits 18:3
// - threshold bytes at 0x25/0x26, reset zero
// - activity after programmed consecutive count, reset one
// - high-pass code zero disables the filter
// - first-order high-pass, corner scales with rate
// - rate field selects output and low-pass rate
// - filter register 0x28 resets to zero
// - activity routed to irq one/two by map
// - results are 20-bit left-justified two's complement
module aof_top
   import aof_pkg::*;
#(
   parameter int W = AXIS_W
) (
   // clock and reset
   input  wire logic                CLK_IN,
   input  wire logic                SYS_RST_IN,
   // register port from the serial interface
   input  wire logic [7:0]          REG_ADDR_IN,
   input  wire logic [7:0]          REG_WDATA_IN,
   input  wire logic                REG_WR_IN,
   input  wire logic                REG_RD_IN,
   output logic [7:0]               REG_RDATA_OUT,
   // raw samples from the converter, one strobe per output sample
   input  wire logic                SAMPLE_VALID_IN,
   input  wire logic signed [W-1:0] X_AXIS_RAW_IN,
   input  wire logic signed [W-1:0] Y_AXIS_RAW_IN,
   input  wire logic signed [W-1:0] Z_AXIS_RAW_IN,
   // processed results
   output logic                     RESULT_VALID_OUT,
   output logic signed [W-1:0]      X_AXIS_RESULT_OUT,
   output logic signed [W-1:0]      Y_AXIS_RESULT_OUT,
   output logic signed [W-1:0]      Z_AXIS_RESULT_OUT,
   // rate control to the decimator
   output logic [3:0]               RATE_LOWPASS_SEL_OUT,
   // activity and interrupt pins
   output logic                     MOTION_DETECT_OUT,
   output logic                     IRQ_OUT_ONE_OUT,
   output logic                     IRQ_OUT_TWO_OUT
);
   if (W != AXIS_W) begin : g_bad_width
      $error("aof_top: result width must be 20");
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0] z_offset_trim_high_reg;
   logic [7:0] z_offset_trim_low_reg;
   logic [7:0] motion_axis_enables_reg;
   logic [7:0] motion_threshold_high_reg;
   logic [7:0] motion_threshold_low_reg;
   logic [7:0] motion_event_count_reg;
   logic [7:0] signal_path_config_reg;
   logic [7:0] irq_routing_reg;

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         z_offset_trim_high_reg    <= BYTE_RESET;
         z_offset_trim_low_reg     <= BYTE_RESET;
         motion_axis_enables_reg   <= BYTE_RESET;
         motion_threshold_high_reg <= BYTE_RESET;
         motion_threshold_low_reg  <= BYTE_RESET;
         motion_event_count_reg    <= EVENT_COUNT_RESET;
         signal_path_config_reg    <= PATH_CONFIG_RESET;
         irq_routing_reg           <= BYTE_RESET;
      end else if (REG_WR_IN) begin
         unique case (REG_ADDR_IN)
            Z_OFFSET_TRIM_HIGH_ADDR: begin
               z_offset_trim_high_reg <= REG_WDATA_IN;
            end
            Z_OFFSET_TRIM_LOW_ADDR: begin
               z_offset_trim_low_reg <= REG_WDATA_IN;
            end
            MOTION_AXIS_ENABLES_ADDR: begin
               motion_axis_enables_reg <= REG_WDATA_IN
                                          & AXIS_ENABLE_MASK;
            end
            MOTION_THRESHOLD_HIGH_ADDR: begin
               motion_threshold_high_reg <= REG_WDATA_IN;
            end
            MOTION_THRESHOLD_LOW_ADDR: begin
               motion_threshold_low_reg <= REG_WDATA_IN;
            end
            MOTION_EVENT_COUNT_ADDR: begin
               motion_event_count_reg <= REG_WDATA_IN;
            end
            SIGNAL_PATH_CONFIG_ADDR: begin
               // undefined codes are stored as written
               signal_path_config_reg <= REG_WDATA_IN
                                         & PATH_CONFIG_MASK;
            end
            IRQ_ROUTING_ADDR: begin
               irq_routing_reg <= REG_WDATA_IN;
            end
            default: begin
            end
         endcase
      end
   end

   // read data registered, unmapped addresses read zero
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         REG_RDATA_OUT <= 8'h00;
      end else if (REG_RD_IN) begin
         unique case (REG_ADDR_IN)
            Z_OFFSET_TRIM_HIGH_ADDR:
               REG_RDATA_OUT <= z_offset_trim_high_reg;
            Z_OFFSET_TRIM_LOW_ADDR:
               REG_RDATA_OUT <= z_offset_trim_low_reg;
            MOTION_AXIS_ENABLES_ADDR:
               REG_RDATA_OUT <= motion_axis_enables_reg;
            MOTION_THRESHOLD_HIGH_ADDR:
               REG_RDATA_OUT <= motion_threshold_high_reg;
            MOTION_THRESHOLD_LOW_ADDR:
               REG_RDATA_OUT <= motion_threshold_low_reg;
            MOTION_EVENT_COUNT_ADDR:
               REG_RDATA_OUT <= motion_event_count_reg;
            SIGNAL_PATH_CONFIG_ADDR:
               REG_RDATA_OUT <= signal_path_config_reg;
            IRQ_ROUTING_ADDR:
               REG_RDATA_OUT <= irq_routing_reg;
            default:
               REG_RDATA_OUT <= 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // high-pass stage per axis
   // ---------------------------------------------------------------
   logic [2:0] hpf_sel;
   assign hpf_sel = signal_path_config_reg[HPF_SEL_LSB +: 3];
   // rate change reaches the decimator; filter runs per sample, so the
   // corner follows the selected rate without retuning
   assign RATE_LOWPASS_SEL_OUT =
      signal_path_config_reg[RATE_SEL_LSB +: 4];

   logic signed [W-1:0] raw   [3];
   logic signed [W-1:0] hp    [3];
   logic [2:0]          hp_vld;
   assign raw[0] = X_AXIS_RAW_IN;
   assign raw[1] = Y_AXIS_RAW_IN;
   assign raw[2] = Z_AXIS_RAW_IN;

   for (genvar i = 0; i < 3; i++) begin : g_axis
      aof_hpf #(.W(W)) u_hpf (
         .clk           (CLK_IN),
         .rst           (SYS_RST_IN),
         .valid_in      (SAMPLE_VALID_IN),
         .sample_in     (raw[i]),
         .corner_sel_in (hpf_sel),
         .valid_out     (hp_vld[i]),
         .sample_out    (hp[i])
      );
   end

   // ---------------------------------------------------------------
   // z trim, last stage of the path
   // ---------------------------------------------------------------
   logic signed [TRIM_W-1:0] z_trim;
   logic signed [W:0]        z_sum;
   assign z_trim = {z_offset_trim_high_reg, z_offset_trim_low_reg};
   assign z_sum  = {hp[2][W-1], hp[2]}
                 + {z_trim[TRIM_W-1], z_trim, {TRIM_ALIGN_LSB{1'b0}}};

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         RESULT_VALID_OUT  <= 1'b0;
         X_AXIS_RESULT_OUT <= '0;
         Y_AXIS_RESULT_OUT <= '0;
         Z_AXIS_RESULT_OUT <= '0;
      end else begin
         RESULT_VALID_OUT <= &hp_vld;
         if (&hp_vld) begin
            X_AXIS_RESULT_OUT <= hp[0];
            Y_AXIS_RESULT_OUT <= hp[1];
            // saturate rather than wrap on large trims
            if (z_sum[W] != z_sum[W-1]) begin
               Z_AXIS_RESULT_OUT <= z_sum[W] ? {1'b1, {(W-1){1'b0}}}
                                             : {1'b0, {(W-1){1'b1}}};
            end else begin
               Z_AXIS_RESULT_OUT <= z_sum[W-1:0];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // activity detection on the final results
   // ---------------------------------------------------------------
   logic [THRESH_W-1:0] threshold;
   logic signed [W-1:0] res [3];
   logic [2:0]          above;
   logic                event_hit;
   assign threshold = {motion_threshold_high_reg, motion_threshold_low_reg};
   assign res[0] = X_AXIS_RESULT_OUT;
   assign res[1] = Y_AXIS_RESULT_OUT;
   assign res[2] = Z_AXIS_RESULT_OUT;

   for (genvar i = 0; i < 3; i++) begin : g_cmp
      logic [W-1:0] mag;
      // full-scale negative keeps bit 19, so compare 17 bits
      assign mag = res[i][W-1] ? W'(-res[i]) : res[i];
      assign above[i] = motion_axis_enables_reg[i]
         && (mag[W-1:THRESH_ALIGN_LSB] > {1'b0, threshold});
   end
   assign event_hit = |above;

   logic [7:0] evt_cnt_reg;
   logic [8:0] evt_cnt_next;
   logic       act_hit;
   assign evt_cnt_next = {1'b0, evt_cnt_reg} + 9'h001;
   // a count of zero behaves like one
   assign act_hit = event_hit
                 && (evt_cnt_next >= {1'b0, motion_event_count_reg});

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         evt_cnt_reg <= 8'h00;
      end else if (RESULT_VALID_OUT) begin
         if (!event_hit || act_hit) begin
            evt_cnt_reg <= 8'h00;
         end else begin
            evt_cnt_reg <= evt_cnt_next[7:0];
         end
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         MOTION_DETECT_OUT <= 1'b0;
         IRQ_OUT_ONE_OUT   <= 1'b0;
         IRQ_OUT_TWO_OUT   <= 1'b0;
      end else begin
         MOTION_DETECT_OUT <= RESULT_VALID_OUT && act_hit;
         IRQ_OUT_ONE_OUT   <= RESULT_VALID_OUT && act_hit
                              && irq_routing_reg[IRQ_ONE_MOTION_BIT];
         IRQ_OUT_TWO_OUT   <= RESULT_VALID_OUT && act_hit
                              && irq_routing_reg[IRQ_TWO_MOTION_BIT];
      end
   end
endmodule : aof_top

// ===== test/aof_assertions.sv
`timescale 1ns/10ps
module aof_chk
   import aof_pkg::*;
#(
   parameter int W = AXIS_W
) (
   // watched ports
   input wire logic                CLK_IN,
   input wire logic                SYS_RST_IN,
   input wire logic [7:0]          REG_ADDR_IN,
   input wire logic [7:0]          REG_WDATA_IN,
   input wire logic                REG_WR_IN,
   input wire logic                REG_RD_IN,
   input wire logic [7:0]          REG_RDATA_OUT,
   input wire logic                SAMPLE_VALID_IN,
   input wire logic                RESULT_VALID_OUT,
   input wire logic signed [W-1:0] Z_AXIS_RESULT_OUT,
   input wire logic [3:0]          RATE_LOWPASS_SEL_OUT,
   input wire logic                MOTION_DETECT_OUT,
   input wire logic                IRQ_OUT_ONE_OUT,
   input wire logic                IRQ_OUT_TWO_OUT
);
   // ---------------------------------
   // sample path and register port
   // ---------------------------------
   logic [3:0] wr_rate;
   assign wr_rate = REG_WDATA_IN[3:0];
   default clocking dck @(posedge CLK_IN);
   endclocking
   default disable iff (SYS_RST_IN);
   sequence s_result;
      ##2 RESULT_VALID_OUT;
   endsequence
   sequence s_cfg_wr;
      REG_WR_IN && REG_ADDR_IN == SIGNAL_PATH_CONFIG_ADDR;
   endsequence
   result_timing_a:
      assert property (SAMPLE_VALID_IN |-> s_result) else $error("late result");
   motion_origin_a:
      assert property (MOTION_DETECT_OUT |-> $past(SAMPLE_VALID_IN, 3))
      else $error("stray motion");
   // results must not drift between strobes, the host reads them any time
   result_hold_a:
      assert property (!RESULT_VALID_OUT |-> $stable(Z_AXIS_RESULT_OUT))
      else $error("result moved");
   rate_follow_a:
      assert property (s_cfg_wr |=> RATE_LOWPASS_SEL_OUT == $past(wr_rate))
      else $error("rate mismatch");
   enable_rsvd_a:
      assert property (REG_RD_IN && REG_ADDR_IN == MOTION_AXIS_ENABLES_ADDR
         |=> REG_RDATA_OUT[7:3] == 5'h00) else $error("enable rsvd set");
   config_rsvd_a:
      assert property (REG_RD_IN && REG_ADDR_IN == SIGNAL_PATH_CONFIG_ADDR
         |=> !REG_RDATA_OUT[7]) else $error("config rsvd set");
   irq_one_a: assert property (IRQ_OUT_ONE_OUT |-> MOTION_DETECT_OUT)
      else $error("irq one stray");
   irq_two_a: assert property (IRQ_OUT_TWO_OUT |-> MOTION_DETECT_OUT)
      else $error("irq two stray");
endmodule : aof_chk
bind aof_top aof_chk #(.W(W)) aof_chk_inst (.CLK_IN, .SYS_RST_IN,
   .REG_ADDR_IN, .REG_WDATA_IN, .REG_WR_IN, .REG_RD_IN, .REG_RDATA_OUT,
   .SAMPLE_VALID_IN, .RESULT_VALID_OUT, .Z_AXIS_RESULT_OUT,
   .RATE_LOWPASS_SEL_OUT, .MOTION_DETECT_OUT, .IRQ_OUT_ONE_OUT,
   .IRQ_OUT_TWO_OUT);

// ===== test/aof_host.sv
`timescale 1ns/10ps
module aof_host (
   // register port of the device
   input  wire logic       clk,
   input  wire logic [7:0] rdata_in,
   output logic [7:0]      addr_out,
   output logic [7:0]      wdata_out,
   output logic            wr_out,
   output logic            rd_out
);
   initial begin
      addr_out  = 8'h00;
      wdata_out = 8'h00;
      wr_out    = 1'b0;
      rd_out    = 1'b0;
   end
   // ---------------------------------
   // one-cycle strobes off the falling edge
   // ---------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr_out  = a;
      wdata_out = d;
      wr_out    = 1'b1;
      @(negedge clk);
      wr_out    = 1'b0;
   endtask : wr
   // read data is registered, so it is taken a cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      addr_out = a;
      rd_out   = 1'b1;
      @(negedge clk);
      rd_out   = 1'b0;
      @(negedge clk);
      d        = rdata_in;
   endtask : rd
endmodule : aof_host

// ===== test/tb.sv
`timescale 1ns/10ps
module tb;
   import aof_pkg::*;
   localparam int W = AXIS_W;
   logic                clk, rst, s_vld, r_vld, motion, irq1, irq2;
   logic signed [W-1:0] x_raw, y_raw, z_raw, x_res, y_res, z_res;
   logic [7:0]          a, wd, rdat;
   logic                reg_wr, reg_rd;
   logic [3:0]          rate_sel;
   logic [19:0]         mcnt, c1, c2;
   int                  error_cnt, n_compared, cyc;
   // address, write data, expected read back
   logic [23:0] rows [9] = '{24'h22_A5A5, 24'h23_5A5A, 24'h24_FF07,
      24'h25_C3C3, 24'h26_3C3C, 24'h27_8080, 24'h28_EA6A, 24'h2A_FFFF,
      24'h30_FF00};
   aof_top #(.W(W)) aof_top_inst (.CLK_IN(clk), .SYS_RST_IN(rst),
      .REG_ADDR_IN(a), .REG_WDATA_IN(wd), .REG_WR_IN(reg_wr),
      .REG_RD_IN(reg_rd), .REG_RDATA_OUT(rdat), .SAMPLE_VALID_IN(s_vld),
      .X_AXIS_RAW_IN(x_raw), .Y_AXIS_RAW_IN(y_raw), .Z_AXIS_RAW_IN(z_raw),
      .RESULT_VALID_OUT(r_vld), .X_AXIS_RESULT_OUT(x_res),
      .Y_AXIS_RESULT_OUT(y_res), .Z_AXIS_RESULT_OUT(z_res),
      .RATE_LOWPASS_SEL_OUT(rate_sel), .MOTION_DETECT_OUT(motion),
      .IRQ_OUT_ONE_OUT(irq1), .IRQ_OUT_TWO_OUT(irq2));
   aof_host aof_host_inst (.clk(clk), .rdata_in(rdat), .addr_out(a),
      .wdata_out(wd), .wr_out(reg_wr), .rd_out(reg_rd));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // pulse counters, cleared while reset is high; cycle count never is
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rst) begin
         mcnt <= '0;
         c1   <= '0;
         c2   <= '0;
      end else begin
         mcnt <= mcnt + 20'(motion);
         c1   <= c1 + 20'(irq1);
         c2   <= c2 + 20'(irq2);
      end
      if (cyc == 32'h0000_1388) begin
         error_cnt++;
         summarize();
      end
   end
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      aof_host_inst.wr(ad, d);
   endtask : wr
   task automatic rdchk(input logic [7:0] ad, input logic [7:0] e);
      logic [7:0] v;
      aof_host_inst.rd(ad, v);
      chk({12'h000, v}, {12'h000, e});
   endtask : rdchk
   task automatic smp(input logic [19:0] x, input logic [19:0] y);
      @(negedge clk);
      x_raw = x;
      y_raw = y;
      z_raw = 20'h0_0010;
      s_vld = 1'b1;
      @(negedge clk);
      s_vld = 1'b0;
      repeat (3) @(negedge clk);
   endtask : smp
   task automatic summarize();
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize
   initial begin
      rst = 1'b1;
      s_vld = 1'b0;
      x_raw = '0;
      y_raw = '0;
      z_raw = '0;
      error_cnt = 0;
      n_compared = 0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 9; i++) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rdchk(rows[i][23:16], rows[i][7:0]);
      end
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      for (logic [7:0] ad = 8'h22; ad < 8'h2B; ad++) begin
         rdchk(ad, (ad == 8'h27) ? 8'h01 : 8'h00);
      end
      chk({16'h0000, rate_sel}, 20'h0_0000);
      for (int i = 0; i < 11; i++) begin
         wr(8'h28, {1'b0, 3'(i % 7), 4'(i)});
         chk({16'h0000, rate_sel}, 20'(i));
         rdchk(8'h28, {1'b0, 3'(i % 7), 4'(i)});
      end
      wr(8'h28, 8'h00);
      wr(8'h23, 8'h10);
      smp(20'h0_1234, 20'h0_0000);
      chk(x_res, 20'h0_1234);
      chk(z_res, 20'h0_0110);
      wr(8'h22, 8'hFF);
      wr(8'h23, 8'hFF);
      smp(20'h0_0000, 20'h0_0000);
      chk(z_res, 20'h0_0000);
      wr(8'h2A, 8'h88);
      wr(8'h24, 8'h01);
      wr(8'h25, 8'h01);
      wr(8'h26, 8'h10);
      wr(8'h27, 8'h02);
      smp(20'h0_0888, 20'h0_0000);
      smp(20'hF_F778, 20'h0_0000);
      chk(mcnt, 20'h0_0001);
      smp(20'h0_0880, 20'h0_0000);
      smp(20'h0_0888, 20'h0_0000);
      smp(20'h0_0000, 20'h4_0000);
      chk(y_res, 20'h4_0000);
      smp(20'h0_0888, 20'h0_0000);
      chk(mcnt, 20'h0_0001);
      wr(8'h2A, 8'h08);
      smp(20'h0_0888, 20'h0_0000);
      chk(mcnt, 20'h0_0002);
      chk(c1, 20'h0_0002);
      chk(c2, 20'h0_0001);
      // corner code one: first sample passes, then dc starts to decay
      wr(8'h28, 8'h10);
      smp(20'h0_1000, 20'h0_0000);
      chk(x_res, 20'h0_1000);
      smp(20'h0_1000, 20'h0_0000);
      chk(x_res, 20'h0_0FC0);
      summarize();
   end
endmodule : tb
